// ==== test/sdcif_array_mdl.sv ====
// array side model: takes write words, returns data tied to the column
`timescale 1ns/1ps
module sdcif_array_mdl (
   input  wire        clk,
   input  wire        hold,
   input  wire [7:0]  burst_col,
   input  wire        wr_valid,
   output wire        wr_ready,
   input  wire [27:0] wr_word,
   output wire [15:0] rd_data
);
   reg [27:0] q [$];
   // ready is hold inverted: a stall backs words up in the core's fifo
   assign wr_ready = ~hold;
   assign rd_data  = {8'hA5, burst_col};
   // collect every word the write fifo hands over
   always @(posedge clk) if (wr_valid && wr_ready) q.push_back(wr_word);
endmodule // sdcif_array_mdl

// ==== test/sdcif_core_tb.sv ====
// self-checking testbench for the dram command interface core
`timescale 1ns/1ps
module sdcif_core_tb;
   reg         clk = 0, reset_n = 0, clk_gate = 1, cs_n = 1, bs = 0, lm = 0, um = 0, hold = 0;
   reg  [2:0]  cmd = 3'h7;
   reg  [10:0] ad = 11'h000;
   reg  [15:0] dq = 16'h0000;
   wire        wr_valid, wr_ready, burst_active, self_refresh, refresh_pulse, burst_is_write, suspended;
   wire [7:0]  burst_col;
   wire [15:0] dq_out, dq_oe, rd_data;
   wire [27:0] wr_word;
   wire [6:0]  mode_reg;
   wire [1:0]  bank_open;
   wire [10:0] row_a, row_b;
   integer     fails = 0, compares = 0;
   always #12.5 clk = ~clk;
   sdcif_core dut (.clk, .reset_n, .clk_gate, .chip_sel_n(cs_n), .row_strobe_n(cmd[2]),
      .col_strobe_n(cmd[1]), .write_strobe_n(cmd[0]), .address_inputs(ad), .bank_select_bit(bs),
      .lower_byte_mask(lm), .upper_byte_mask(um), .dq_in(dq), .dq_out, .dq_oe, .wr_valid,
      .wr_ready, .wr_word, .rd_data, .mode_reg, .bank_open, .row_a, .row_b, .burst_active,
      .burst_col, .burst_is_write, .self_refresh, .refresh_pulse, .suspended);
   sdcif_array_mdl mdl (.clk, .hold, .burst_col, .wr_valid, .wr_ready, .wr_word, .rd_data);
   // compare and count
   task chk(input [31:0] e, s, input [63:0] n);
      begin
         compares = compares + 1;
         if (e !== s) begin
            fails = fails + 1;
            $display("MISMATCH %0s exp %h got %h", n, e, s);
         end
      end
   endtask
   // one command with chip select low, then standby
   task op(input [2:0] c, input [11:0] a, input [1:0] m = 2'h0);
      begin
         @(posedge clk);
         {cs_n, cmd, bs, ad, um, lm} <= {1'b0, c, a, m};
         @(posedge clk);
         {cs_n, cmd, um, lm} <= 6'h3C;
         #1;
      end
   endtask
   task mr(input [6:0] a, e);
      begin
         op(3'h0, {5'h00, a});
         chk(e, mode_reg, "mode");
      end
   endtask
   // eight beat write into a stalled array side, then drain in order
   task t_fifo;
      integer i, n;
      begin
         mr(7'h13, 7'h13);
         op(3'h3, 12'h005);
         n = mdl.q.size();
         @(posedge clk);
         {cs_n, cmd, bs, ad, dq} <= {4'h4, 12'h010, 16'h0000};
         hold <= 1;
         for (i = 1; i < 8; i = i + 1) begin
            @(posedge clk);
            {cs_n, cmd, dq} <= {4'hF, i[15:0]};
         end
         repeat (3) @(posedge clk);
         #1;
         chk(1, wr_valid, "fill");
         chk(n, mdl.q.size(), "stall");
         chk(1, burst_is_write, "is_write");
         @(posedge clk);
         hold <= 0;
         repeat (12) @(posedge clk);
         #1;
         chk(n + 8, mdl.q.size(), "drained");
         for (i = 0; i < 8; i = i + 1) begin
            chk({4'h0, 8'h10 + i[7:0], i[15:0]}, mdl.q[n + i], "drain");
         end
         op(3'h2, 12'h400);
      end
   endtask
   task t_mode;
      begin
         mr(7'h10, 7'h10);
         mr(7'h21, 7'h21);
         mr(7'h32, 7'h32);
         mr(7'h27, 7'h27);
         mr(7'h2F, 7'h2B);
         mr(7'h1B, 7'h1B);
         @(posedge clk);
         {cmd, ad} <= 14'h007F;
         @(posedge clk);
         cmd <= 3'h7;
         #1;
         chk(7'h1B, mode_reg, "ignored");
      end
   endtask
   task t_act;
      begin
         op(3'h3, 12'h5A3);
         op(3'h3, 12'hAC4);
         chk(11'h5A3, row_a, "row_a");
         chk(11'h2C4, row_b, "row_b");
         chk(2'b11, bank_open, "open");
         op(3'h2, 12'h800);
         chk(2'b01, bank_open, "pre_b");
         op(3'h2, 12'hC00);
         chk(2'b00, bank_open, "pre_all");
      end
   endtask
   task t_read;
      integer i, k, h;
      begin
         mr(7'h2B, 7'h2B);
         op(3'h3, 12'h011);
         op(3'h5, 12'h002, 2'h1);
         k = 0;
         h = 0;
         for (i = 0; i < 16; i = i + 1) begin
            @(posedge clk);
            #1;
            if (dq_oe !== 16'h0000) begin
               if (dq_oe === 16'hFF00) h = h + 1;
               else chk({8'hA5, 8'h02 ^ k[7:0]}, dq_out, "rd_beat");
               k = k + 1;
            end
         end
         chk(8, k, "beats");
         chk(1, h, "masked");
         op(3'h2, 12'h400);
      end
   endtask
   task t_write;
      begin
         mr(7'h12, 7'h12);
         op(3'h3, 12'h801);
         @(posedge clk);
         {cs_n, cmd, bs, ad, dq} <= {4'h4, 12'hC06, 16'h1111};
         @(posedge clk);
         {cs_n, cmd, lm, dq} <= {5'h1F, 16'h2222};
         @(posedge clk);
         {um, dq} <= {1'b1, 16'h3333};
         @(posedge clk);
         {um, lm, dq} <= {2'h0, 16'h4444};
         repeat (12) @(posedge clk);
         #1;
         chk(3, mdl.q.size(), "words");
         chk(28'h4061111, mdl.q[0], "word0");
         chk(28'h5072222, mdl.q[1], "word1");
         chk(28'h4054444, mdl.q[2], "word2");
         chk(2'b00, bank_open, "auto_pre");
      end
   endtask
   task t_page;
      reg [7:0] s;
      begin
         mr(7'h17, 7'h17);
         op(3'h3, 12'h022);
         op(3'h5, 12'h000);
         repeat (300) @(posedge clk);
         #1;
         chk(1, burst_active, "page_run");
         @(posedge clk);
         clk_gate <= 0;
         #1;
         s = burst_col;
         repeat (3) @(posedge clk);
         #1;
         chk(s, burst_col, "suspend");
         chk(1, suspended, "suspflag");
         @(posedge clk);
         clk_gate <= 1;
         op(3'h6, 12'h000);
         chk(0, burst_active, "stopped");
         op(3'h2, 12'h400);
      end
   endtask
   task t_ref;
      begin
         op(3'h1, 12'h000);
         chk(1, refresh_pulse, "auto_ref");
         @(posedge clk);
         {cs_n, cmd, clk_gate} <= 5'h02;
         @(posedge clk);
         {cs_n, cmd} <= 4'hF;
         #1;
         chk(1, self_refresh, "self_ref");
      end
   endtask
   task summarize;
      begin
         $display("compares %0d fails %0d", compares, fails);
         if (fails == 0 && compares > 0) begin
            $display("Result: passed");
         end else begin
            $display("Result: failed");
         end
         $finish;
      end
   endtask
   // main sequence after a six cycle reset
   initial begin
      repeat (6) @(posedge clk);
      reset_n <= 1;
      t_mode;
      t_act;
      t_read;
      t_write;
      t_fifo;
      t_page;
      t_ref;
      summarize;
   end
   // watchdog: about twelve times the expected run
   initial begin
      #125000;
      fails = fails + 1;
      summarize;
   end
endmodule // sdcif_core_tb

// ==== test/sdcif_sva.sv ====
// assertion checker for the dram command interface core
`timescale 1ns/1ps
module sdcif_sva #(parameter DQ_W = 16, parameter COL_W = 8) (
   // clock, reset and command pins
   input wire              clk, reset_n, clk_gate, chip_sel_n,
   input wire              row_strobe_n, col_strobe_n, write_strobe_n,
   input wire [10:0]       address_inputs,
   input wire              bank_select_bit, lower_byte_mask, upper_byte_mask,
   // observed state
   input wire [DQ_W-1:0]   dq_oe,
   input wire [6:0]        mode_reg,
   input wire [1:0]        bank_open,
   input wire [10:0]       row_a, row_b,
   input wire [COL_W-1:0]  burst_col,
   input wire              burst_active, self_refresh, refresh_pulse
);
   // decoded strobes and expected mode value (interleave page folds to 8)
   wire [2:0] c    = {row_strobe_n, col_strobe_n, write_strobe_n};
   wire       go   = !chip_sel_n && clk_gate && !self_refresh;
   wire [2:0] bl   = address_inputs[2:0];
   wire [6:0] mr_e = {address_inputs[6:3], (address_inputs[3] && bl == 3'h7) ? 3'h3 : bl};
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   property p_act; go && c == 3'h3 |=> bank_open[$past(bank_select_bit)] &&
      ($past(bank_select_bit) ? row_b : row_a) == $past(address_inputs); endproperty
   a_act: assert property (p_act) else $error("activate row or bank wrong");
   property p_pre_all; go && c == 3'h2 && address_inputs[10] |=> bank_open == 2'b00; endproperty
   a_pre_all: assert property (p_pre_all) else $error("precharge all left a bank open");
   property p_pre_one; go && c == 3'h2 && !address_inputs[10] |=> !bank_open[$past(bank_select_bit)]; endproperty
   a_pre_one: assert property (p_pre_one) else $error("selected bank not closed");
   property p_mode; go && c == 3'h0 |=> mode_reg == $past(mr_e); endproperty
   a_mode: assert property (p_mode) else $error("mode register value wrong");
   property p_cs; chip_sel_n |=> $stable(mode_reg) && $stable(row_a) && $stable(row_b); endproperty
   a_cs: assert property (p_cs) else $error("deselected command took effect");
   property p_gate; !clk_gate |=> $stable(burst_col) && $stable(burst_active); endproperty
   a_gate: assert property (p_gate) else $error("burst moved while clock gated");
   property p_ref; go && c == 3'h1 |=> refresh_pulse ##1 !refresh_pulse; endproperty
   a_ref: assert property (p_ref) else $error("refresh pulse wrong");
   property p_self; !chip_sel_n && !clk_gate && c == 3'h1 |=> self_refresh; endproperty
   a_self: assert property (p_self) else $error("self refresh not entered");
   property p_rmask; lower_byte_mask |=> ##2 dq_oe[7:0] == 8'h00; endproperty
   a_rmask: assert property (p_rmask) else $error("lower byte still driven");
   property p_umask; upper_byte_mask |=> ##2 dq_oe[DQ_W-1:8] == 8'h00; endproperty
   a_umask: assert property (p_umask) else $error("upper byte still driven");
   property p_rd; go && c == 3'h5 |=> burst_col == $past(address_inputs[COL_W-1:0]); endproperty
   a_rd: assert property (p_rd) else $error("read start column wrong");
   c_il: cover property (go && c == 3'h5 && mode_reg[3]);
   c_wr: cover property (go && c == 3'h4 && bank_select_bit);
   c_sr: cover property (self_refresh);
endmodule // sdcif_sva
bind sdcif_core sdcif_sva #(.DQ_W(DQ_W), .COL_W(COL_W)) u_sva (.clk, .reset_n, .clk_gate, .chip_sel_n,
   .row_strobe_n, .col_strobe_n, .write_strobe_n, .address_inputs, .bank_select_bit,
   .lower_byte_mask, .upper_byte_mask, .dq_oe, .mode_reg, .bank_open, .row_a, .row_b,
   .burst_col, .burst_active, .self_refresh, .refresh_pulse);

// ==== verilog/sdcif_consts.vh ====
// constants for the synchronous dram command interface model
`ifndef SDCIF_CONSTS_VH
`define SDCIF_CONSTS_VH
// command codes {ras_n, cas_n, we_n}
`define SDCIF_CMD_ACT      3'h3
`define SDCIF_CMD_READ     3'h5
`define SDCIF_CMD_WRITE    3'h4
`define SDCIF_CMD_PRE      3'h2
`define SDCIF_CMD_BST      3'h6
`define SDCIF_CMD_NOP      3'h7
`define SDCIF_CMD_MRS      3'h0
`define SDCIF_CMD_REF      3'h1
// mode register field positions
`define SDCIF_MR_BL_LSB    0
`define SDCIF_MR_WRAP_BIT  3
`define SDCIF_MR_LAT_LSB   4
// burst length codes
`define SDCIF_BL_1         3'h0
`define SDCIF_BL_2         3'h1
`define SDCIF_BL_4         3'h2
`define SDCIF_BL_8         3'h3
`define SDCIF_BL_PAGE      3'h7
// mode register reset value: latency 1, length 1, sequential
`define SDCIF_MR_RESET     7'h10
// address bit positions
`define SDCIF_AP_BIT       10
// read mask to output disable latency in clocks
`define SDCIF_DQM_RD_LAT   2
`endif

// ==== verilog/sdcif_core.v ====
// command decoder, bank and burst control of a dual bank synchronous dram
//
// Behaviour
// - inputs sampled only on rising clock edge
// - clock gate high runs, low suspends
// - chip select high ignores new commands
// - decode activate, read and write patterns
// - decode precharge, burst stop and no-op
// - decode mode set and refresh entry
// - activate latches eleven bit row address
// - column from low address bits per organisation
// - flag bit selects automatic precharge after burst, except after a single beat write or a full page burst
// - precharge flag high closes both banks
// - bank select low bank a, high b
// - read mask floats outputs two clocks later
// - write mask blocks same edge data
// - mode holds latency, burst length, wrap type
// - full page only with sequential wrap
// - burst columns generated, wrap in block
// - interleaved column is start xor beat
// - refresh with gate high auto, low self
// - full page burst runs until interrupted
`timescale 1ns/1ps
`include "sdcif_consts.vh"
module sdcif_core #(
   parameter DQ_W   = 16,
   parameter COL_W  = 8,
   parameter FIFO_D = 8,
   parameter FIFO_A = 3
) (
   // clock and reset
   input  wire              clk,
   input  wire              reset_n,
   // command pins
   input  wire              clk_gate,
   input  wire              chip_sel_n,
   input  wire              row_strobe_n,
   input  wire              col_strobe_n,
   input  wire              write_strobe_n,
   input  wire [10:0]       address_inputs,
   input  wire              bank_select_bit,
   input  wire              lower_byte_mask,
   input  wire              upper_byte_mask,
   // data pins, split
   input  wire [DQ_W-1:0]   dq_in,
   output reg  [DQ_W-1:0]   dq_out,
   output reg  [DQ_W-1:0]   dq_oe,
   // array side: write words leave through the fifo
   output wire              wr_valid,
   input  wire              wr_ready,
   output wire [DQ_W+COL_W+3:0] wr_word,
   input  wire [DQ_W-1:0]   rd_data,
   // status
   output reg  [6:0]        mode_reg,
   output reg  [1:0]        bank_open,
   output reg  [10:0]       row_a,
   output reg  [10:0]       row_b,
   output reg               burst_active,
   output reg  [COL_W-1:0]  burst_col,
   output reg               burst_is_write,
   output reg               self_refresh,
   output reg               refresh_pulse,
   output reg               suspended
);
   // ------------------------------------------------------------
   // command decode
   // ------------------------------------------------------------
   wire [2:0] cmd     = {row_strobe_n, col_strobe_n, write_strobe_n};
   wire       gate_on = clk_gate & ~self_refresh;
   wire       cmd_ok  = ~chip_sel_n & gate_on;
   wire       is_act  = cmd_ok & (cmd == `SDCIF_CMD_ACT);
   wire       is_rd   = cmd_ok & (cmd == `SDCIF_CMD_READ);
   wire       is_wr   = cmd_ok & (cmd == `SDCIF_CMD_WRITE);
   wire       is_pre  = cmd_ok & (cmd == `SDCIF_CMD_PRE);
   wire       is_bst  = cmd_ok & (cmd == `SDCIF_CMD_BST);
   wire       is_mrs  = cmd_ok & (cmd == `SDCIF_CMD_MRS);
   wire       is_ref  = ~chip_sel_n & ~self_refresh & (cmd == `SDCIF_CMD_REF);
   wire       ap_flag = address_inputs[`SDCIF_AP_BIT];      // precharge_flag_bit

   // ------------------------------------------------------------
   // burst length and column sequencing
   // ------------------------------------------------------------
   reg  [COL_W-1:0] start_col_r;
   reg  [COL_W-1:0] beat_r;
   reg  [COL_W-1:0] blen_mask;
   reg  [COL_W-1:0] col_nxt;
   reg              last_beat;
   reg              ap_r;
   reg              ap_bank_r;
   reg              bank_r;
   reg  [COL_W-1:0] beat_nxt;
   wire [2:0]       bl_code = mode_reg[`SDCIF_MR_BL_LSB +: 3];
   wire             wrap_il = mode_reg[`SDCIF_MR_WRAP_BIT];
   wire [COL_W-1:0] new_col = address_inputs[COL_W-1:0];

   // mask of the aligned block size minus one
   always @* begin
      case (bl_code)
         `SDCIF_BL_1:    blen_mask = {COL_W{1'b0}};
         `SDCIF_BL_2:    blen_mask = {{(COL_W-1){1'b0}}, 1'b1};
         `SDCIF_BL_4:    blen_mask = {{(COL_W-2){1'b0}}, 2'h3};
         `SDCIF_BL_8:    blen_mask = {{(COL_W-3){1'b0}}, 3'h7};
         `SDCIF_BL_PAGE: blen_mask = {COL_W{1'b1}};
         default:        blen_mask = {COL_W{1'b0}};
      endcase
   end

   // next column: wrap inside the aligned block
   always @* begin
      beat_nxt  = beat_r + 1'b1;
      last_beat = ((beat_r & blen_mask) == blen_mask) && (bl_code != `SDCIF_BL_PAGE);
      if (wrap_il) begin
         col_nxt = (start_col_r & ~blen_mask) | ((start_col_r ^ beat_nxt) & blen_mask);
      end else begin
         col_nxt = (start_col_r & ~blen_mask) | ((start_col_r + beat_nxt) & blen_mask);
      end
   end

   // ------------------------------------------------------------
   // read data path with mask and latency pipeline
   // ------------------------------------------------------------
   reg  [1:0]       rd_vld_pipe_r;
   reg  [DQ_W-1:0]  rd_dat_pipe_r [0:1];
   reg  [1:0]       mask_d1_r;
   reg  [1:0]       mask_d2_r;
   wire [2:0]       lat = mode_reg[`SDCIF_MR_LAT_LSB +: 3];
   wire [DQ_W-1:0]  mask_wide;
   wire             rd_beat = burst_active & ~burst_is_write & gate_on;
   wire             wr_beat = (burst_active & burst_is_write & gate_on) | is_wr;
   wire [1:0]       mask_now = {upper_byte_mask, lower_byte_mask};
   wire [COL_W-1:0] wr_col   = is_wr ? new_col : burst_col;

   // per bit output disable from the twice delayed mask
   genvar gi;
   generate
      for (gi = 0; gi < DQ_W; gi = gi + 1) begin : g_mask
         assign mask_wide[gi] = mask_d2_r[(gi >= DQ_W/2) ? 1 : 0];
      end
   endgenerate

   // ------------------------------------------------------------
   // write fifo: {bank, byte mask, column, data}
   // ------------------------------------------------------------
   wire wr_push = wr_beat & ~(&mask_now);
   wire fifo_in_ready;

   sdcif_fifo #(
      .WIDTH (DQ_W + COL_W + 4),
      .DEPTH (FIFO_D),
      .AW    (FIFO_A)
   ) u_wfifo (
      .clk       (clk),
      .reset_n   (reset_n),
      .in_valid  (wr_push),
      .in_ready  (fifo_in_ready),
      .in_data   ({1'b0, is_wr ? bank_select_bit : bank_r, mask_now, wr_col, dq_in}),
      .out_valid (wr_valid),
      .out_ready (wr_ready),
      .out_data  (wr_word)
   );

   // ------------------------------------------------------------
   // clock suspend and refresh
   // ------------------------------------------------------------
   // suspend flag follows the gate; refresh kind chosen by gate level
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         suspended     <= 1'b0;
         refresh_pulse <= 1'b0;
         self_refresh  <= 1'b0;
      end else begin
         suspended     <= ~clk_gate;
         refresh_pulse <= is_ref & clk_gate;
         if (is_ref & ~clk_gate) begin
            self_refresh <= 1'b1;
         end else if (self_refresh & clk_gate) begin
            self_refresh <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // main sequential state, all on the rising edge
   // ------------------------------------------------------------
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mode_reg       <= `SDCIF_MR_RESET;
         bank_open      <= 2'h0;
         row_a          <= 11'h000;
         row_b          <= 11'h000;
         burst_active   <= 1'b0;
         burst_col      <= {COL_W{1'b0}};
         burst_is_write <= 1'b0;
         start_col_r    <= {COL_W{1'b0}};
         beat_r         <= {COL_W{1'b0}};
         ap_r           <= 1'b0;
         ap_bank_r      <= 1'b0;
         bank_r         <= 1'b0;
         rd_vld_pipe_r  <= 2'h0;
         mask_d1_r      <= 2'h0;
         mask_d2_r      <= 2'h0;
         dq_out         <= {DQ_W{1'b0}};
         dq_oe          <= {DQ_W{1'b0}};
      end else begin
         if (gate_on) begin
            mask_d1_r <= mask_now;
            mask_d2_r <= mask_d1_r;
            // read latency pipeline: stage index is latency minus two
            rd_vld_pipe_r <= {rd_vld_pipe_r[0], rd_beat};
            dq_out <= (lat == 3'h1) ? rd_data :
                      (lat == 3'h2) ? rd_dat_pipe_r[0] : rd_dat_pipe_r[1];
            dq_oe  <= ~mask_wide & {DQ_W{
                      (lat == 3'h1) ? rd_beat :
                      (lat == 3'h2) ? rd_vld_pipe_r[0] : rd_vld_pipe_r[1]}};
            if (is_mrs) begin
               mode_reg <= address_inputs[6:0];
               if (address_inputs[`SDCIF_MR_WRAP_BIT] &&
                   address_inputs[2:0] == `SDCIF_BL_PAGE) begin
                  mode_reg[2:0] <= `SDCIF_BL_8;
               end
            end
            if (is_act) begin
               if (bank_select_bit) begin
                  row_b        <= address_inputs;
                  bank_open[1] <= 1'b1;
               end else begin
                  row_a        <= address_inputs;
                  bank_open[0] <= 1'b1;
               end
            end
            if (is_rd | is_wr) begin
               burst_active   <= ~(is_wr & (bl_code == `SDCIF_BL_1));
               burst_is_write <= is_wr;
               start_col_r    <= new_col;
               burst_col      <= is_wr ? col_nxt_first(new_col) : new_col;
               beat_r         <= is_wr ? {{(COL_W-1){1'b0}}, 1'b1} : {COL_W{1'b0}};
               ap_r           <= ap_flag;
               ap_bank_r      <= bank_select_bit;
               bank_r         <= bank_select_bit;
            end else if (is_bst | is_pre) begin
               burst_active <= 1'b0;
            end else if (burst_active) begin
               if (last_beat) begin
                  burst_active <= 1'b0;
                  if (ap_r) begin
                     bank_open[ap_bank_r] <= 1'b0;
                  end
               end else begin
                  burst_col <= col_nxt;
                  beat_r    <= beat_nxt;
               end
            end
            if (is_pre) begin
               if (ap_flag) begin
                  bank_open <= 2'h0;
               end else begin
                  bank_open[bank_select_bit] <= 1'b0;
               end
            end
         end
      end
   end

   // read data staging for latencies two and three
   always @(posedge clk) begin
      if (gate_on) begin
         rd_dat_pipe_r[0] <= rd_data;
         rd_dat_pipe_r[1] <= rd_dat_pipe_r[0];
      end
   end

   // second column of a write burst, first beat is taken on the command edge
   function [COL_W-1:0] col_nxt_first;
      input [COL_W-1:0] c;
      begin
         if (wrap_il) begin
            col_nxt_first = (c & ~blen_mask) | ((c ^ {{(COL_W-1){1'b0}}, 1'b1}) & blen_mask);
         end else begin
            col_nxt_first = (c & ~blen_mask) | ((c + 1'b1) & blen_mask);
         end
      end
   endfunction

   // fifo back-pressure is visible as a dropped word only if ignored by the array
   wire unused_ready = fifo_in_ready;
endmodule // sdcif_core

// parameterised synchronous fifo with valid and ready on both sides
module sdcif_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = 8,
   parameter AW    = 3
) (
   // clock and reset
   input  wire             clk,
   input  wire             reset_n,
   // fill side
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   // drain side
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem_r [0:DEPTH-1];
   reg [AW-1:0]    wp_r;
   reg [AW-1:0]    rp_r;
   reg [AW:0]      cnt_r;
   wire            push;
   wire            pop;

   assign in_ready  = (cnt_r != DEPTH[AW:0]);
   assign out_valid = (cnt_r != {(AW+1){1'b0}});
   assign out_data  = mem_r[rp_r];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // storage write
   always @(posedge clk) begin
      if (push) begin
         mem_r[wp_r] <= in_data;
      end
   end

   // pointers and count
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wp_r  <= {AW{1'b0}};
         rp_r  <= {AW{1'b0}};
         cnt_r <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wp_r <= (wp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= (rp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
         end
         cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end
endmodule // sdcif_fifo

// ==== verilog/sdcif_fifo.v ====
// holds no logic: the write fifo module is kept in the core file
